// ===== dspma_pkg.sv
// Shared constants, modes and multiply functions of the DSP multiplier-adder block
package dspma_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int W9 = 9;            // Small multiplier operand
  localparam int W18 = 18;          // Medium multiplier operand
  localparam int W36 = 36;          // Wide multiplier operand
  localparam int WLIM = 35;         // Operand limit for mixed sign kinds
  localparam int WIN = 72;          // Operand bus width per side
  localparam int WRES = 144;        // Result bus width

  // ----------------------------------------------------------------
  // Reset values and latency codes
  // ----------------------------------------------------------------
  localparam logic [143:0] RES_RST = 144'h0;
  localparam logic [71:0] OPD_RST = 72'h0;
  localparam logic [1:0] LAT_NONE = 2'h0;   // Unregistered
  localparam logic [1:0] LAT_ONE = 2'h1;    // Registered once
  localparam logic [1:0] LAT_TWO = 2'h2;    // Registered twice

  // ----------------------------------------------------------------
  // Operating modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    DM_MUL9   = 7'h01,  // Eight 9x9 products
    DM_MUL18  = 7'h02,  // Four 18x18 products
    DM_MUL36  = 7'h04,  // One 36x36 product
    DM_ADD2_18 = 7'h08, // Two sums of two 18x18 products
    DM_ADD2_9 = 7'h10,  // Four sums of two 9x9 products
    DM_ADD4_18 = 7'h20, // One sum of four 18x18 products
    DM_ADD4_9 = 7'h40   // Two sums of four 9x9 products
  } dspma_mode_t;

  // ----------------------------------------------------------------
  // Multiply helpers
  // ----------------------------------------------------------------
  // 9x9 product; each sign flag high treats its operand as signed
  function automatic logic [17:0] mul9(input logic [8:0] a, input logic [8:0] b,
                                       input logic sa, input logic sb);
    logic signed [9:0] ea;
    logic signed [9:0] eb;
    logic signed [19:0] p;
    ea = signed'({sa & a[8], a});
    eb = signed'({sb & b[8], b});
    p = ea * eb;
    return p[17:0];
  endfunction

  // 18x18 product with the same sign handling
  function automatic logic [35:0] mul18(input logic [17:0] a, input logic [17:0] b,
                                        input logic sa, input logic sb);
    logic signed [18:0] ea;
    logic signed [18:0] eb;
    logic signed [37:0] p;
    ea = signed'({sa & a[17], a});
    eb = signed'({sb & b[17], b});
    p = ea * eb;
    return p[35:0];
  endfunction

endpackage

// ===== dspma_latsel.sv
// Selectable zero, one or two register delay for control bundles
`timescale 1ns/100ps
module dspma_latsel
  import dspma_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and clears
  input wire logic clk,
  input wire logic rst_n,
  input wire logic aclr,
  input wire logic ena,
  // Latency select and data
  input wire logic [1:0] sel,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;   // First delay stage
  logic [W-1:0] s2;   // Second delay stage

  // ----------------------------------------------------------------
  // Delay stages
  // ----------------------------------------------------------------
  // Async clear to zero, hold while the enable is low
  always_ff @(posedge clk or posedge aclr) begin
    if (aclr) begin
      s1 <= '0;
      s2 <= '0;
    end else if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
    end else if (ena) begin
      s1 <= d;
      s2 <= s1;
    end
  end

  // Tap select; code 3 behaves as two registers
  always_comb begin
    if (sel == LAT_NONE) begin
      q = d;
    end else if (sel == LAT_ONE) begin
      q = s1;
    end else begin
      q = s2;
    end
  end

  two_reg_a: assert property (@(posedge clk) disable iff (!rst_n || aclr)
    (sel == LAT_TWO && ena) ##1 ena |=> q == $past(d, 2))
    else $error("two-register control delay wrong");

endmodule

// ===== dspma_mulcore.sv
// Wide 36x36 multiplier with fixed, dynamic and shared sign handling
`timescale 1ns/100ps
module dspma_mulcore
  import dspma_pkg::*;
(
  // Operands
  input wire logic [35:0] a,
  input wire logic [35:0] b,
  // Sign kind: dynamic flag, fixed sign value, dynamic sign value
  input wire logic a_dyn,
  input wire logic b_dyn,
  input wire logic a_fix,
  input wire logic b_fix,
  input wire logic sa_dyn,
  input wire logic sb_dyn,
  input wire logic shared,
  // Product and limit flags
  output logic [71:0] p,
  output logic lim_a,
  output logic lim_b
);

  logic sa;                 // Effective sign of a
  logic sb;                 // Effective sign of b
  logic [35:0] la;          // Limited a
  logic [35:0] lb;          // Limited b
  logic signed [36:0] ea;   // Extended a
  logic signed [36:0] eb;   // Extended b
  logic signed [73:0] pw;   // Full product

  // Shared control drives both operands, so no width loss then
  always_comb begin
    sa = shared ? sa_dyn : (a_dyn ? sa_dyn : a_fix);
    sb = shared ? sa_dyn : (b_dyn ? sb_dyn : b_fix);
  end

  // Mixed kinds leave one spare bit for the sign, hence 35 bits
  always_comb begin
    lim_a = !shared && ((!a_dyn && !a_fix && !b_dyn && b_fix)
                        || (a_dyn && !b_dyn && b_fix)
                        || (!a_dyn && !a_fix && b_dyn)
                        || (a_dyn && b_dyn));
    lim_b = !shared && ((!b_dyn && !b_fix && !a_dyn && a_fix)
                        || (b_dyn && !a_dyn && a_fix)
                        || (!b_dyn && !b_fix && a_dyn)
                        || (a_dyn && b_dyn));
  end

  // Limited operand keeps 35 bits, top bit rebuilt from its sign
  always_comb begin
    la = lim_a ? {sa & a[34], a[34:0]} : a;
    lb = lim_b ? {sb & b[34], b[34:0]} : b;
    ea = signed'({sa & la[35], la});
    eb = signed'({sb & lb[35], lb});
    pw = ea * eb;
    p = pw[71:0];
  end

endmodule

// ===== dspma_top.sv
// DSP multiplier-adder block: split or wide multipliers, adders and pipeline
//
// Operation
// - eight 9x9, four 18x18 or one 36x36
// - matched fixed signs give full 36x36 product
// - unsigned by signed: unsigned operand 35 bits
// - dynamic by signed: dynamic operand 35 bits
// - dynamic by unsigned: unsigned operand 35 bits
// - separate dynamic controls: both operands 35 bits
// - one shared dynamic control: full 36x36
// - two-multiplier sums of 18-bit or 9-bit pairs
// - complex real subtracts, imaginary adds cross terms
// - two 9-bit complex products use four adders
// - second stage sums two first-stage adders
// - four-multiplier sum uses equal product widths
// - first-stage controls unregistered or registered once
// - later controls zero, one or two registers
`timescale 1ns/100ps
module dspma_top
  import dspma_pkg::*;
(
  // Clock, reset, enable and clear
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic ENA,
  input wire logic ACLR,
  // Operands: eight 9-bit, four 18-bit or one 36-bit lane per side
  input wire logic [71:0] DATA_A,
  input wire logic [71:0] DATA_B,
  // Sign configuration and dynamic sign controls
  input wire logic A_DYN,
  input wire logic B_DYN,
  input wire logic A_FIX_SIGNED,
  input wire logic B_FIX_SIGNED,
  input wire logic SHARED_SIGN,
  input wire logic SIGN_A,
  input wire logic SIGN_B,
  // First-stage add/subtract, high adds
  input wire logic [3:0] ADD_NSUB,
  // Mode and pipeline configuration
  input wire dspma_mode_t MODE,
  input wire logic IN_REG,
  input wire logic PIPE_REG,
  input wire logic CTL1_REG,
  input wire logic [1:0] CTL2_LAT,
  // Results
  output logic [143:0] RESULT,
  output logic LIMIT_A,
  output logic LIMIT_B
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [71:0] a_q;             // Input register, side A
  logic [71:0] b_q;             // Input register, side B
  logic [71:0] a_s;             // Operand A after optional register
  logic [71:0] b_s;             // Operand B after optional register
  logic [6:0] ctl1_d;           // Signs and add/subtract bundle
  logic [6:0] ctl1_q;           // Same, after first-stage latency
  logic sa;                     // Lane sign of A
  logic sb;                     // Lane sign of B
  logic [3:0] addsub;           // Aligned add/subtract
  logic [143:0] prod;           // Raw products, lane packed
  logic [71:0] p36;             // Wide product
  logic lim_a;                  // A operand limited to 35 bits
  logic lim_b;                  // B operand limited to 35 bits
  logic [143:0] prod_q;         // Pipeline register after multipliers
  logic [143:0] prod_s;         // Products after optional register
  logic [3:0] addsub_q;         // Add/subtract aligned to pipeline
  logic sgn_q;                  // Lane signedness aligned to pipeline
  logic [8:0] ctl2_d;           // Mode and limit flags for later stage
  logic [8:0] ctl2_q;           // Same, after selected latency
  dspma_mode_t mode_s;          // Mode seen by the adders
  logic [143:0] next_result;    // Result before the output register

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sign-extend a first-stage 18-bit-lane sum to 72 bits
  function automatic logic [71:0] ext37(input logic [36:0] v, input logic s);
    return {{35{s & v[36]}}, v};
  endfunction

  // Sign-extend a first-stage 9-bit-lane sum to 36 bits
  function automatic logic [35:0] ext19(input logic [18:0] v, input logic s);
    return {{17{s & v[18]}}, v};
  endfunction

  // Add or subtract two products of a width, extended one bit
  function automatic logic [36:0] as36(input logic [35:0] x, input logic [35:0] y,
                                       input logic s, input logic add);
    logic [36:0] ex;
    logic [36:0] ey;
    ex = {s & x[35], x};
    ey = {s & y[35], y};
    return add ? ex + ey : ex - ey;
  endfunction

  function automatic logic [18:0] as18(input logic [17:0] x, input logic [17:0] y,
                                       input logic s, input logic add);
    logic [18:0] ex;
    logic [18:0] ey;
    ex = {s & x[17], x};
    ey = {s & y[17], y};
    return add ? ex + ey : ex - ey;
  endfunction

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  // Optional operand capture; held while the enable is low
  always_ff @(posedge CLK or posedge ACLR) begin
    if (ACLR) begin
      a_q <= OPD_RST;
      b_q <= OPD_RST;
    end else if (!RESETN) begin
      a_q <= OPD_RST;
      b_q <= OPD_RST;
    end else if (ENA) begin
      a_q <= DATA_A;
      b_q <= DATA_B;
    end
  end

  // Bypass mux for the input stage
  always_comb begin
    a_s = IN_REG ? a_q : DATA_A;
    b_s = IN_REG ? b_q : DATA_B;
  end

  // ----------------------------------------------------------------
  // First-stage controls
  // ----------------------------------------------------------------
  // Dynamic signs must arrive with their operand; CTL1_REG, not IN_REG, sets their delay
  always_comb begin
    ctl1_d = {SIGN_A, SIGN_B, ADD_NSUB, 1'b0};
  end

  dspma_latsel #(.W(7)) u_ctl1 (
    .clk(CLK),
    .rst_n(RESETN),
    .aclr(ACLR),
    .ena(ENA),
    .sel({1'b0, CTL1_REG}),
    .d(ctl1_d),
    .q(ctl1_q)
  );

  // Lane signs for the split modes follow the same selection
  always_comb begin
    sa = SHARED_SIGN ? ctl1_q[6] : (A_DYN ? ctl1_q[6] : A_FIX_SIGNED);
    sb = SHARED_SIGN ? ctl1_q[6] : (B_DYN ? ctl1_q[5] : B_FIX_SIGNED);
    addsub = ctl1_q[4:1];
  end

  // ----------------------------------------------------------------
  // Multipliers
  // ----------------------------------------------------------------
  dspma_mulcore u_mul36 (
    .a(a_s[35:0]),
    .b(b_s[35:0]),
    .a_dyn(A_DYN),
    .b_dyn(B_DYN),
    .a_fix(A_FIX_SIGNED),
    .b_fix(B_FIX_SIGNED),
    .sa_dyn(ctl1_q[6]),
    .sb_dyn(ctl1_q[5]),
    .shared(SHARED_SIGN),
    .p(p36),
    .lim_a(lim_a),
    .lim_b(lim_b)
  );

  // One product array serves all modes; the mode picks the lane split
  always_comb begin
    prod = RES_RST;
    if (MODE == DM_MUL9 || MODE == DM_ADD2_9 || MODE == DM_ADD4_9) begin
      for (int i = 0; i < 8; i++) begin
        prod[18*i +: 18] = mul9(a_s[9*i +: 9], b_s[9*i +: 9], sa, sb);
      end
    end else if (MODE == DM_MUL36) begin
      prod[71:0] = p36;
    end else begin
      for (int i = 0; i < 4; i++) begin
        prod[36*i +: 36] = mul18(a_s[18*i +: 18], b_s[18*i +: 18], sa, sb);
      end
    end
  end

  // ----------------------------------------------------------------
  // Pipeline register
  // ----------------------------------------------------------------
  // Products and their aligned first-stage controls move together
  always_ff @(posedge CLK or posedge ACLR) begin
    if (ACLR) begin
      prod_q <= RES_RST;
      addsub_q <= 4'h0;
      sgn_q <= 1'b0;
    end else if (!RESETN) begin
      prod_q <= RES_RST;
      addsub_q <= 4'h0;
      sgn_q <= 1'b0;
    end else if (ENA) begin
      prod_q <= prod;
      addsub_q <= addsub;
      sgn_q <= sa | sb;
    end
  end

  // Bypass mux for the pipeline stage
  always_comb begin
    prod_s = PIPE_REG ? prod_q : prod;
  end

  // ----------------------------------------------------------------
  // Later-stage controls
  // ----------------------------------------------------------------
  always_comb begin
    ctl2_d = {MODE, lim_a, lim_b};
  end

  dspma_latsel #(.W(9)) u_ctl2 (
    .clk(CLK),
    .rst_n(RESETN),
    .aclr(ACLR),
    .ena(ENA),
    .sel(CTL2_LAT),
    .d(ctl2_d),
    .q(ctl2_q)
  );

  always_comb begin
    mode_s = dspma_mode_t'(ctl2_q[8:2]);
  end

  // ----------------------------------------------------------------
  // Adders
  // ----------------------------------------------------------------
  // Only same-width lanes meet in an adder, so mixed widths never sum
  always_comb begin
    logic [36:0] s18_0;
    logic [36:0] s18_1;
    logic [18:0] s9 [4];
    logic add_s;
    logic [3:0] op;
    s18_0 = '0;
    s18_1 = '0;
    s9 = '{default: '0};
    add_s = PIPE_REG ? sgn_q : (sa | sb);
    op = PIPE_REG ? addsub_q : addsub;
    for (int k = 0; k < 4; k++) begin
      s9[k] = as18(prod_s[36*k +: 18], prod_s[36*k+18 +: 18], add_s, op[k]);
    end
    s18_0 = as36(prod_s[35:0], prod_s[71:36], add_s, op[0]);
    s18_1 = as36(prod_s[107:72], prod_s[143:108], add_s, op[1]);
    next_result = RES_RST;
    unique case (mode_s)
      DM_MUL9, DM_MUL18: begin
        next_result = prod_s;
      end
      DM_MUL36: begin
        next_result = {{72{1'b0}}, prod_s[71:0]};
      end
      DM_ADD2_18: begin
        next_result = {ext37(s18_1, add_s), ext37(s18_0, add_s)};
      end
      DM_ADD2_9: begin
        next_result = {ext19(s9[3], add_s), ext19(s9[2], add_s),
                       ext19(s9[1], add_s), ext19(s9[0], add_s)};
      end
      DM_ADD4_18: begin
        next_result = {{72{1'b0}}, ext37(s18_0, add_s) + ext37(s18_1, add_s)};
      end
      DM_ADD4_9: begin
        next_result = {{72{1'b0}}, ext19(s9[2], add_s) + ext19(s9[3], add_s),
                       ext19(s9[0], add_s) + ext19(s9[1], add_s)};
      end
      default: begin
        next_result = RES_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Outputs always leave through a register so timing is fixed
  always_ff @(posedge CLK or posedge ACLR) begin
    if (ACLR) begin
      RESULT <= RES_RST;
      LIMIT_A <= 1'b0;
      LIMIT_B <= 1'b0;
    end else if (!RESETN) begin
      RESULT <= RES_RST;
      LIMIT_A <= 1'b0;
      LIMIT_B <= 1'b0;
    end else if (ENA) begin
      RESULT <= next_result;
      LIMIT_A <= ctl2_q[1];
      LIMIT_B <= ctl2_q[0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence bypass_s;
    ENA && !IN_REG && !PIPE_REG && !CTL1_REG && CTL2_LAT == LAT_NONE;
  endsequence

  lane9_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (MODE == DM_MUL9 && !A_DYN && !B_DYN && !SHARED_SIGN) |=>
    RESULT[17:0] == mul9($past(DATA_A[8:0]), $past(DATA_B[8:0]), $past(A_FIX_SIGNED), $past(B_FIX_SIGNED)))
    else $error("9x9 lane product wrong");

  wide_uu_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (MODE == DM_MUL36 && !A_DYN && !B_DYN && !SHARED_SIGN && !A_FIX_SIGNED && !B_FIX_SIGNED) |=>
    RESULT[71:0] == $past(DATA_A[35:0]) * $past(DATA_B[35:0]) && !LIMIT_A && !LIMIT_B)
    else $error("unsigned 36x36 product wrong");

  mixed_lim_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (!A_DYN && !B_DYN && !SHARED_SIGN && !A_FIX_SIGNED && B_FIX_SIGNED) |=> LIMIT_A && !LIMIT_B)
    else $error("unsigned operand not limited");

  dyn_sgn_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (A_DYN && !B_DYN && B_FIX_SIGNED && !SHARED_SIGN) |=> LIMIT_A && !LIMIT_B)
    else $error("dynamic operand not limited");

  dyn_uns_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (!A_DYN && !A_FIX_SIGNED && B_DYN && !SHARED_SIGN) |=> LIMIT_A && !LIMIT_B)
    else $error("unsigned beside dynamic not limited");

  both_dyn_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (A_DYN && B_DYN && !SHARED_SIGN) |=> LIMIT_A && LIMIT_B)
    else $error("separate dynamic controls not limited");

  shared_sgn_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (SHARED_SIGN && MODE == DM_MUL36) |=> !LIMIT_A && !LIMIT_B)
    else $error("shared control limited an operand");

  cplx_real_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    bypass_s and (MODE == DM_ADD2_18 && !ADD_NSUB[0] && !A_DYN && !B_DYN && !SHARED_SIGN
    && !A_FIX_SIGNED && !B_FIX_SIGNED) |=>
    RESULT[36:0] == $past(DATA_A[17:0]) * $past(DATA_B[17:0]) - $past(DATA_A[35:18]) * $past(DATA_B[35:18]))
    else $error("complex real part wrong");

  ctl1_once_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    (ENA && CTL1_REG) ##1 (ENA && CTL1_REG) |-> addsub == $past(ADD_NSUB))
    else $error("first-stage control not registered once");

  clr_zero_a: assert property (@(posedge CLK)
    ACLR |-> RESULT == RES_RST && !LIMIT_A && !LIMIT_B)
    else $error("clear did not zero outputs");

  hold_en_a: assert property (@(posedge CLK) disable iff (!RESETN || ACLR)
    !ENA |=> $stable(RESULT))
    else $error("result moved without enable");

endmodule

// ===== dspma_fabric.sv
// Fabric model: drives operands and their dynamic sign controls
`timescale 1ns/100ps
module dspma_fabric (
  // Operands toward the block
  output logic [71:0] data_a,
  output logic [71:0] data_b,
  // Dynamic signs, high means signed
  output logic sign_a,
  output logic sign_b
);
  // Quiet, defined values from time zero
  initial begin
    data_a = 72'h0;
    data_b = 72'h0;
    sign_a = 1'b0;
    sign_b = 1'b0;
  end

  // One call moves operands and signs together, so no cycle pairs stale signs
  task automatic put(input logic [71:0] a, input logic [71:0] b, input logic sa, input logic sb);
    data_a = a;
    data_b = b;
    sign_a = sa;
    sign_b = sb;
  endtask
endmodule

// ===== dspma_tb_top.sv
// Testbench of the multiplier-adder block: mode table, sign table, latency walks
`timescale 1ns/100ps
module dspma_tb_top;
  import dspma_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [71:0] OPA = 72'hf3_a51c_7e9b_24d6_805e; // Mixed-sign lanes
  localparam logic [71:0] OPB = 72'h8c_27f1_d03b_e9a6_41c5;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic ENA = 1'b1;
  logic ACLR = 1'b0;
  logic [4:0] sgn = 5'b00110; // Dyn A, dyn B, fixed A, fixed B, shared
  logic [4:0] pcfg = 5'b00000; // In reg, pipe reg, ctl1 reg, ctl2 latency
  logic [3:0] ADD_NSUB = 4'h0;
  dspma_mode_t MODE = DM_MUL9;
  logic [71:0] DATA_A;
  logic [71:0] DATA_B;
  logic SIGN_A;
  logic SIGN_B;
  logic [143:0] RESULT;
  logic LIMIT_A;
  logic LIMIT_B;
  int errors = 0;
  int check_count = 0;

  always #50 CLK = ~CLK;

  dspma_fabric dspma_fabric_i (.data_a(DATA_A), .data_b(DATA_B), .sign_a(SIGN_A), .sign_b(SIGN_B));

  dspma_top dspma_top_i (.CLK(CLK), .RESETN(RESETN), .ENA(ENA), .ACLR(ACLR), .DATA_A(DATA_A),
    .DATA_B(DATA_B), .A_DYN(sgn[4]), .B_DYN(sgn[3]), .A_FIX_SIGNED(sgn[2]), .B_FIX_SIGNED(sgn[1]),
    .SHARED_SIGN(sgn[0]), .SIGN_A(SIGN_A), .SIGN_B(SIGN_B), .ADD_NSUB(ADD_NSUB), .MODE(MODE),
    .IN_REG(pcfg[4]), .PIPE_REG(pcfg[3]), .CTL1_REG(pcfg[2]), .CTL2_LAT(pcfg[1:0]),
    .RESULT(RESULT), .LIMIT_A(LIMIT_A), .LIMIT_B(LIMIT_B));

  // ----------------------------------------------------------------
  // Reference arithmetic, kept apart from the design's helpers
  // ----------------------------------------------------------------
  // Product of the low w bits of each side, extended to 72 bits
  function automatic logic [71:0] pm(logic [35:0] a, logic [35:0] b, int w, logic sa, logic sb);
    logic signed [73:0] ea;
    logic signed [73:0] eb;
    logic signed [73:0] p;
    for (int i = 0; i < 74; i++) begin
      ea[i] = (i < w) ? a[i] : (sa & a[w-1]);
      eb[i] = (i < w) ? b[i] : (sb & b[w-1]);
    end
    p = ea * eb;
    return p[71:0];
  endfunction

  // Whole result bus for one mode and lane width
  function automatic logic [143:0] expect_res(dspma_mode_t m, int w, logic sa, logic sb, logic [3:0] an,
                                              logic [71:0] a, logic [71:0] b);
    logic [71:0] pr [8];
    logic [71:0] sm [4];
    logic [143:0] e;
    e = 144'h0;
    for (int i = 0; i < 72 / w; i++) pr[i] = pm(36'(a >> (i * w)), 36'(b >> (i * w)), w, sa, sb);
    for (int k = 0; k < 36 / w; k++) sm[k] = an[k] ? pr[2*k] + pr[2*k+1] : pr[2*k] - pr[2*k+1];
    case (m)
      DM_MUL36: e = 144'(pr[0]);
      DM_ADD2_18: e = {sm[1], sm[0]};
      DM_ADD4_18: e = {72'h0, sm[0] + sm[1]};
      DM_ADD2_9: e = {36'(sm[3]), 36'(sm[2]), 36'(sm[1]), 36'(sm[0])};
      DM_ADD4_9: e = 144'({36'(sm[2] + sm[3]), 36'(sm[0] + sm[1])});
      default: for (int i = 0; i < 72 / w; i++) e = e | ((144'(pr[i]) & ~(~144'h0 << (2 * w))) << (2 * w * i));
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Access tasks, entered at a falling edge except the two checks made 10 ns into the clear
  // ----------------------------------------------------------------
  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Fixed signed operands, all registers bypassed: one edge to the answer
  task automatic mode_run(input dspma_mode_t m, input int w, input logic [3:0] an);
    sgn = 5'b00110;
    MODE = m;
    ADD_NSUB = an;
    dspma_fabric_i.put(OPA, OPB, 1'b0, 1'b0);
    @(negedge CLK);
    check(RESULT, expect_res(m, w, 1'b1, 1'b1, an, OPA, OPB));
  endtask

  // Wide product under one sign setup; ea/eb are the effective signs
  task automatic w36(input logic [4:0] c, input logic sa, input logic sb, input logic [35:0] a,
                     input logic [35:0] b, input logic ea, input logic eb, input logic [1:0] lim);
    sgn = c;
    MODE = DM_MUL36;
    dspma_fabric_i.put(72'(a), 72'(b), sa, sb);
    @(negedge CLK);
    check(RESULT, 144'(pm(a, b, 36, ea, eb)));
    check(144'({LIMIT_A, LIMIT_B}), 144'(lim));
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few dozen cycles the tests need
  initial begin
    #200000;
    errors = errors + 1;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    @(negedge CLK);
    mode_run(DM_MUL9, 9, 4'h0);
    mode_run(DM_MUL18, 18, 4'h0);
    mode_run(DM_MUL36, 36, 4'h0);
    mode_run(DM_ADD2_18, 18, 4'h2);
    mode_run(DM_ADD2_9, 9, 4'ha);
    mode_run(DM_ADD4_18, 18, 4'h3);
    mode_run(DM_ADD4_9, 9, 4'h5);
    w36(5'b00000, 1'b0, 1'b0, 36'hc_5e21_9b07, 36'h9_0f3d_2a61, 1'b0, 1'b0, 2'h0);
    w36(5'b00010, 1'b0, 1'b0, 36'h3_9a4c_17e5, 36'hc_5e21_9b07, 1'b0, 1'b1, 2'h2);
    w36(5'b00100, 1'b0, 1'b0, 36'hc_5e21_9b07, 36'h3_9a4c_17e5, 1'b1, 1'b0, 2'h1);
    w36(5'b10010, 1'b1, 1'b0, 36'hc_5e21_9b07, 36'h9_0f3d_2a61, 1'b1, 1'b1, 2'h2);
    w36(5'b10000, 1'b1, 1'b0, 36'hc_5e21_9b07, 36'h3_9a4c_17e5, 1'b1, 1'b0, 2'h1);
    w36(5'b01000, 1'b0, 1'b1, 36'h3_9a4c_17e5, 36'hc_5e21_9b07, 1'b0, 1'b1, 2'h2);
    w36(5'b11000, 1'b0, 1'b1, 36'h3_9a4c_17e5, 36'hc_5e21_9b07, 1'b0, 1'b1, 2'h3);
    w36(5'b00001, 1'b1, 1'b0, 36'hc_5e21_9b07, 36'h9_0f3d_2a61, 1'b1, 1'b1, 2'h0);
    w36(5'b00001, 1'b0, 1'b1, 36'hc_5e21_9b07, 36'h9_0f3d_2a61, 1'b0, 1'b0, 2'h0);
    // Unsigned real part with a positive difference, so the sum needs no sign
    sgn = 5'b00000;
    MODE = DM_ADD2_18;
    ADD_NSUB = 4'h2;
    dspma_fabric_i.put(72'h7_ffff, 72'hf_ffff, 1'b0, 1'b0);
    @(negedge CLK);
    check(RESULT, expect_res(DM_ADD2_18, 18, 1'b0, 1'b0, 4'h2, 72'h7_ffff, 72'hf_ffff));
    // Signs change every cycle, so a misaligned control stage shows at once
    for (int j = 0; j < 2; j++) begin
      pcfg = j ? 5'b11110 : 5'b10101;
      sgn = 5'b11000;
      MODE = DM_MUL18;
      ADD_NSUB = 4'h3;
      dspma_fabric_i.put(OPA, OPB, 1'b1, 1'b0);
      @(negedge CLK);
      ADD_NSUB = 4'hc;
      dspma_fabric_i.put(OPB, OPA, 1'b0, 1'b1);
      repeat (j + 1) @(negedge CLK);
      check(RESULT, expect_res(DM_MUL18, 18, 1'b1, 1'b0, 4'h0, OPA, OPB));
      @(negedge CLK);
      check(RESULT, expect_res(DM_MUL18, 18, 1'b0, 1'b1, 4'h0, OPB, OPA));
    end
    // Enable low freezes everything, clear empties it without a clock
    ENA = 1'b0;
    dspma_fabric_i.put(OPA, OPA, 1'b1, 1'b1);
    repeat (3) @(negedge CLK);
    check(RESULT, expect_res(DM_MUL18, 18, 1'b0, 1'b1, 4'h0, OPB, OPA));
    ACLR = 1'b1;
    #10;
    check(RESULT, 144'h0);
    check(144'({LIMIT_A, LIMIT_B}), 144'h0);
    @(negedge CLK);
    ACLR = 1'b0;
    ENA = 1'b1;
    report_and_stop();
  end
endmodule
